// ### common/ptm_pkg.sv
/*
 Constants, types and pin bundle layout for the mode register and
 non-volatile store block. Assumes a single 20 MHz system clock.
*/
package ptm_pkg;

	////////////////////////////////////////////////////////////////////
	// Widths
	localparam int PTM_MODE_W = 8;
	localparam int PTM_NV_W   = 20;
	localparam int PTM_SYN_W  = 12;

	typedef logic [PTM_MODE_W-1:0] ptm_mode_t;
	typedef logic [PTM_NV_W-1:0]   ptm_word_t;
	typedef logic [PTM_SYN_W-1:0]  ptm_pins_t;

	////////////////////////////////////////////////////////////////////
	// Mode register bit positions
	localparam int PTM_MB_SHADOW_OUT = 1;
	localparam int PTM_MB_MAIN_OUT   = 2;
	localparam int PTM_MB_PDOWN      = 3;
	localparam int PTM_MB_CNT_LOAD   = 4;
	localparam int PTM_MB_MOD_OUT    = 5;
	localparam int PTM_MB_REF_OUT    = 6;

	////////////////////////////////////////////////////////////////////
	// Reset and fixed values
	localparam ptm_mode_t PTM_MODE_RST  = 8'h00;
	localparam ptm_word_t PTM_NV_RST    = 20'h0_0000;
	localparam ptm_word_t PTM_NV_ERASED = 20'hf_ffff;
	localparam ptm_pins_t PTM_PINS_RST  = 12'h000;

	////////////////////////////////////////////////////////////////////
	// Synchronised pin bundle positions
	localparam int PTM_PIN_SCLK   = 0;
	localparam int PTM_PIN_SDATA  = 1;
	localparam int PTM_PIN_MSTRB  = 2;
	localparam int PTM_PIN_SSTRB  = 3;
	localparam int PTM_PIN_NVSEL  = 4;
	localparam int PTM_PIN_NVLD   = 5;
	localparam int PTM_PIN_GATEN  = 6;
	localparam int PTM_PIN_VPPE   = 7;
	localparam int PTM_PIN_VPPW   = 8;
	localparam int PTM_PIN_MAINO  = 9;
	localparam int PTM_PIN_REFO   = 10;
	localparam int PTM_PIN_MODSEL = 11;

	////////////////////////////////////////////////////////////////////
	// Shadow reload sequencer
	typedef enum logic [0:0] {LD_IDLE, LD_WAIT} ptm_ld_e;

endpackage

// ### core/ptm_core.sv
/*
 Serial mode register with holding buffer, gate, output routing, and
 control of erase, write and reload of the non-volatile shadow register.
 Assumes every pin is asynchronous to mclk; serial clock well below mclk/4.
*/

module ptm_core
	import ptm_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  resetn,
	input  wire logic  sclk,
	input  wire logic  sdata,
	input  wire logic  mode_strobe,
	input  wire logic  sec_strobe,
	input  wire logic  nv_select,
	input  wire logic  nv_load,
	input  wire logic  mode_gate_n,
	input  wire logic  vpp_erase,
	input  wire logic  vpp_write,
	input  wire logic  main_divider_out,
	input  wire logic  ref_divider_out,
	input  wire logic  modulus_select,
	output      logic  dout,
	output      logic  power_down,
	output      logic  counter_load_now,
	output      logic  shadow_in_control,
	output      logic  route_conflict,
	output      ptm_pkg::ptm_word_t freq_word
);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection
	ptm_pins_t pins_raw;
	ptm_pins_t pins_s;
	ptm_pins_t prev_r;
	ptm_pins_t prev_nxt;
	ptm_pins_t rise;
	ptm_pins_t fall;

	assign pins_raw = {modulus_select, ref_divider_out, main_divider_out,
		vpp_write, vpp_erase, mode_gate_n, nv_load, nv_select,
		sec_strobe, mode_strobe, sdata, sclk};

	ptm_sync u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (pins_raw),
		.q      (pins_s)
	);

	always_comb begin
		prev_nxt = pins_s;
		rise     = pins_s & ~prev_r;
		fall     = ~pins_s & prev_r;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prev_r <= PTM_PINS_RST;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic more_than_one(input ptm_mode_t m);
		logic [2:0] n;
		n = 3'd0;
		n = n + {2'b00, m[PTM_MB_SHADOW_OUT]};
		n = n + {2'b00, m[PTM_MB_MAIN_OUT]};
		n = n + {2'b00, m[PTM_MB_MOD_OUT]};
		n = n + {2'b00, m[PTM_MB_REF_OUT]};
		return n > 3'd1;
	endfunction

	logic sd_s;
	logic sclk_rise;
	logic ss_s;
	logic sel_s;
	logic ld_s;
	logic gate_n_s;
	logic sel_mode;
	logic sel_shadow;

	always_comb begin
		sd_s       = pins_s[PTM_PIN_SDATA];
		sclk_rise  = rise[PTM_PIN_SCLK];
		ss_s       = pins_s[PTM_PIN_SSTRB];
		sel_s      = pins_s[PTM_PIN_NVSEL];
		ld_s       = pins_s[PTM_PIN_NVLD];
		gate_n_s   = pins_s[PTM_PIN_GATEN];
		sel_mode   = !ss_s && pins_s[PTM_PIN_MSTRB] && !ld_s;
		sel_shadow = !ss_s && ld_s;
	end

	////////////////////////////////////////////////////////////////////
	// Mode shift register and holding buffer
	ptm_mode_t mode_sh_r;
	ptm_mode_t mode_sh_nxt;
	ptm_mode_t hold_r;
	ptm_mode_t hold_nxt;
	ptm_mode_t eff;

	always_comb begin
		mode_sh_nxt = mode_sh_r;
		if (sclk_rise && sel_mode) begin
			mode_sh_nxt = {sd_s, mode_sh_r[PTM_MODE_W-1:1]};
		end
		hold_nxt = hold_r;
		if (fall[PTM_PIN_MSTRB]) begin
			hold_nxt = mode_sh_r;
		end
		eff = gate_n_s ? PTM_MODE_RST : hold_r;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_sh_r <= PTM_MODE_RST;
			hold_r    <= PTM_MODE_RST;
		end else begin
			mode_sh_r <= mode_sh_nxt;
			hold_r    <= hold_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Non-volatile control and shadow register
	ptm_ld_e   ld_st_r;
	ptm_ld_e   ld_st_nxt;
	ptm_word_t shadow_r;
	ptm_word_t shadow_nxt;
	ptm_word_t nv_rd_data;
	logic      reload_go;
	logic      nv_rd_en;
	logic      erase_go;
	logic      write_go;

	always_comb begin
		erase_go  = rise[PTM_PIN_VPPE] && ss_s && sel_s && ld_s;
		write_go  = rise[PTM_PIN_VPPW] && ss_s && !sel_s && ld_s;
		reload_go = (rise[PTM_PIN_NVSEL] && !ld_s) ||
			(fall[PTM_PIN_NVLD] && sel_s);
		ld_st_nxt  = ld_st_r;
		nv_rd_en   = 1'b0;
		shadow_nxt = shadow_r;
		unique case (ld_st_r)
			LD_IDLE: begin
				if (reload_go) begin
					nv_rd_en  = 1'b1;
					ld_st_nxt = LD_WAIT;
				end
			end
			LD_WAIT: begin
				shadow_nxt = nv_rd_data;
				ld_st_nxt  = LD_IDLE;
			end
		endcase
		if (ld_st_r == LD_IDLE && sclk_rise && sel_shadow) begin
			shadow_nxt = {sd_s, shadow_r[PTM_NV_W-1:1]};
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ld_st_r  <= LD_IDLE;
			shadow_r <= PTM_NV_RST;
		end else begin
			ld_st_r  <= ld_st_nxt;
			shadow_r <= shadow_nxt;
		end
	end

	ptm_nv_cells u_cells (
		.mclk    (mclk),
		.resetn  (resetn),
		.erase   (erase_go),
		.write   (write_go),
		.wdata   (shadow_r),
		.rd_en   (nv_rd_en),
		.rd_data (nv_rd_data)
	);

	////////////////////////////////////////////////////////////////////
	// Outputs
	logic      dout_r;
	logic      dout_nxt;
	logic      pdown_r;
	logic      pdown_nxt;
	logic      cload_r;
	logic      cload_nxt;
	logic      sctl_r;
	logic      sctl_nxt;
	logic      conf_r;
	logic      conf_nxt;
	ptm_word_t fw_r;
	ptm_word_t fw_nxt;

	always_comb begin
		dout_nxt =
			(eff[PTM_MB_SHADOW_OUT] && shadow_r[0]) ||
			(eff[PTM_MB_MAIN_OUT] && pins_s[PTM_PIN_MAINO]) ||
			(eff[PTM_MB_MOD_OUT] && pins_s[PTM_PIN_MODSEL]) ||
			(eff[PTM_MB_REF_OUT] && pins_s[PTM_PIN_REFO]);
		pdown_nxt = eff[PTM_MB_PDOWN];
		cload_nxt = eff[PTM_MB_CNT_LOAD];
		conf_nxt  = more_than_one(eff);
		sctl_nxt  = sel_s && !ld_s;
		fw_nxt    = sctl_nxt ? shadow_r : fw_r;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dout_r  <= 1'b0;
			pdown_r <= 1'b0;
			cload_r <= 1'b0;
			sctl_r  <= 1'b0;
			conf_r  <= 1'b0;
			fw_r    <= PTM_NV_RST;
		end else begin
			dout_r  <= dout_nxt;
			pdown_r <= pdown_nxt;
			cload_r <= cload_nxt;
			sctl_r  <= sctl_nxt;
			conf_r  <= conf_nxt;
			fw_r    <= fw_nxt;
		end
	end

	assign dout              = dout_r;
	assign power_down        = pdown_r;
	assign counter_load_now  = cload_r;
	assign shadow_in_control = sctl_r;
	assign route_conflict    = conf_r;
	assign freq_word         = fw_r;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_mode_shift_in: assert property (sclk_rise && sel_mode |=>
		mode_sh_r == {$past(sd_s), $past(mode_sh_r[PTM_MODE_W-1:1])})
		else $error("mode register did not shift");
	chk_hold_only_strobe: assert property (!fall[PTM_PIN_MSTRB] |=>
		$stable(hold_r))
		else $error("buffer changed without strobe");
	chk_hold_capture: assert property (fall[PTM_PIN_MSTRB] |=>
		hold_r == $past(mode_sh_r))
		else $error("buffer missed shifted bits");
	chk_gate_disables: assert property (gate_n_s |=>
		!pdown_r && !cload_r && !dout_r)
		else $error("gate high but mode active");
	chk_pdown_follows: assert property (!gate_n_s && hold_r[PTM_MB_PDOWN]
		|=> pdown_r)
		else $error("power down not asserted");
	chk_shadow_dout: assert property (
		eff == (PTM_MODE_RST | (8'h01 << PTM_MB_SHADOW_OUT)) |=>
		dout_r == $past(shadow_r[0]))
		else $error("shadow bit 0 not on output");
	chk_shadow_shift: assert property (
		ld_st_r == LD_IDLE && sclk_rise && sel_shadow |=>
		shadow_r == {$past(sd_s), $past(shadow_r[PTM_NV_W-1:1])})
		else $error("shadow did not shift in data");
	chk_reload_path: assert property (ld_st_r == LD_IDLE && reload_go
		|=> ld_st_r == LD_WAIT ##1 shadow_r == $past(nv_rd_data))
		else $error("shadow not reloaded from cells");
	chk_freq_word: assert property (sctl_nxt |=>
		freq_word == $past(shadow_r) && shadow_in_control)
		else $error("shadow not in control");

	cov_erase: cover property (erase_go);
	cov_write: cover property (write_go);
	cov_mode_load: cover property (fall[PTM_PIN_MSTRB] && !gate_n_s);
	cov_readback: cover property (eff[PTM_MB_SHADOW_OUT] && sclk_rise
		&& sel_shadow);

endmodule // ptm_core

// ### core/ptm_nv_cells.sv
/*
 Non-volatile cell array model: erase to ones, AND-write, registered read.
 Assumes erase, write and read requests are single-cycle pulses.
*/
module ptm_nv_cells
	import ptm_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire logic               erase,
	input  wire logic               write,
	input  wire ptm_pkg::ptm_word_t wdata,
	input  wire logic               rd_en,
	output      ptm_pkg::ptm_word_t rd_data
);

	ptm_word_t cells_r;
	ptm_word_t cells_nxt;
	ptm_word_t rd_r;
	ptm_word_t rd_nxt;

	////////////////////////////////////////////////////////////////////
	// Cells keep their content through reset
	always_comb begin
		cells_nxt = cells_r;
		if (erase) begin
			cells_nxt = PTM_NV_ERASED;
		end else if (write) begin
			cells_nxt = cells_r & wdata;
		end
		rd_nxt = rd_en ? cells_r : rd_r;
	end

	always_ff @(posedge mclk) begin
		cells_r <= cells_nxt;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_r <= PTM_NV_RST;
		end else begin
			rd_r <= rd_nxt;
		end
	end

	assign rd_data = rd_r;

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_erase_sets_ones: assert property (@(posedge mclk) disable iff (!resetn)
		erase |=> cells_r == PTM_NV_ERASED)
		else $error("erase did not set all cells");
	chk_write_and_all: assert property (@(posedge mclk) disable iff (!resetn)
		write && !erase |=> cells_r == ($past(cells_r) & $past(wdata)))
		else $error("write did not AND all bits at once");

endmodule // ptm_nv_cells

// ### core/ptm_sync.sv
/*
 Two-flop synchroniser for a bundle of asynchronous pins.
 Assumes the inputs are static levels or slow edges against mclk.
*/
module ptm_sync
	import ptm_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire ptm_pkg::ptm_pins_t d,
	output      ptm_pkg::ptm_pins_t q
);

	ptm_pins_t meta_r;
	ptm_pins_t meta_nxt;
	ptm_pins_t q_r;
	ptm_pins_t q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= PTM_PINS_RST;
			q_r    <= PTM_PINS_RST;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q = q_r;

endmodule // ptm_sync

// ### testbench/ptm_core_tb.sv
/*
 Self-checking bench for ptm_core with a programmer model.
 Assumes the package constants; checks at the block's ports only.
*/
module ptm_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ptm_pkg::*;

	localparam ptm_word_t W1   = 20'h5_a3c9;
	localparam ptm_word_t W2   = 20'h3_ff0f;
	localparam ptm_word_t FILL = 20'h6_c0d3;

	logic      mclk;
	logic      resetn;
	logic [2:0] src;
	logic      sclk, sdata, mode_strobe, sec_strobe, nv_select, nv_load;
	logic      mode_gate_n, vpp_erase, vpp_write;
	logic      dout, power_down, counter_load_now, shadow_in_control;
	logic      route_conflict;
	ptm_word_t freq_word;
	int        num_errors = 0;
	int        n_compared = 0;

	always #25 mclk = ~mclk;

	ptm_core i_ptm_core (
		.mclk              (mclk),
		.resetn            (resetn),
		.sclk              (sclk),
		.sdata             (sdata),
		.mode_strobe       (mode_strobe),
		.sec_strobe        (sec_strobe),
		.nv_select         (nv_select),
		.nv_load           (nv_load),
		.mode_gate_n       (mode_gate_n),
		.vpp_erase         (vpp_erase),
		.vpp_write         (vpp_write),
		.main_divider_out  (src[0]),
		.ref_divider_out   (src[1]),
		.modulus_select    (src[2]),
		.dout              (dout),
		.power_down        (power_down),
		.counter_load_now  (counter_load_now),
		.shadow_in_control (shadow_in_control),
		.route_conflict    (route_conflict),
		.freq_word         (freq_word)
	);

	ptm_prog_model i_ptm_prog_model (
		.mclk        (mclk),
		.dout        (dout),
		.sclk        (sclk),
		.sdata       (sdata),
		.mode_strobe (mode_strobe),
		.sec_strobe  (sec_strobe),
		.nv_select   (nv_select),
		.nv_load     (nv_load),
		.mode_gate_n (mode_gate_n),
		.vpp_erase   (vpp_erase),
		.vpp_write   (vpp_write)
	);

	////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input ptm_word_t got, input ptm_word_t exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_mode_gate();
		chk_bit(power_down, 1'h0);
		i_ptm_prog_model.shift_mode(8'h18);
		i_ptm_prog_model.strobe_mode();
		chk_bit(power_down, 1'h0);
		i_ptm_prog_model.set_gate(1'h0);
		chk_bit(power_down, 1'h1);
		chk_bit(counter_load_now, 1'h1);
		i_ptm_prog_model.shift_mode(8'h10);
		chk_bit(power_down, 1'h1);
		i_ptm_prog_model.strobe_mode();
		chk_bit(power_down, 1'h0);
		i_ptm_prog_model.set_gate(1'h1);
		chk_bit(counter_load_now, 1'h0);
		i_ptm_prog_model.set_gate(1'h0);
		chk_bit(counter_load_now, 1'h1);
	endtask

	task automatic t_routing();
		int pos [3] = '{PTM_MB_MAIN_OUT, PTM_MB_REF_OUT, PTM_MB_MOD_OUT};
		for (int k = 0; k < 3; k++) begin
			i_ptm_prog_model.shift_mode(8'h01 << pos[k]);
			i_ptm_prog_model.strobe_mode();
			src = ~(3'h1 << k);
			cycles(6);
			chk_bit(dout, 1'h0);
			chk_bit(route_conflict, 1'h0);
			src = 3'h1 << k;
			cycles(6);
			chk_bit(dout, 1'h1);
		end
		src = 3'h0;
		i_ptm_prog_model.shift_mode(8'h06);
		i_ptm_prog_model.strobe_mode();
		chk_bit(route_conflict, 1'h1);
	endtask

	task automatic read_check(input ptm_word_t exp);
		ptm_word_t got;
		i_ptm_prog_model.reload();
		chk_bit(shadow_in_control, 1'h1);
		chk_word(freq_word, exp);
		i_ptm_prog_model.shift_out(PTM_NV_W, FILL, got);
		i_ptm_prog_model.reload();
		i_ptm_prog_model.shift_out(PTM_NV_W - 1, FILL, got);
		chk_word(got, exp);
		i_ptm_prog_model.shift_out(1, FILL, got);
		chk_word({18'h0_0000, got[1:0]}, {18'h0_0000, FILL[0], exp[19]});
	endtask

	task automatic t_nv();
		i_ptm_prog_model.shift_mode(8'h02);
		i_ptm_prog_model.strobe_mode();
		i_ptm_prog_model.erase();
		i_ptm_prog_model.write_word(W1);
		read_check(W1);
		i_ptm_prog_model.write_word(W2);
		read_check(W1 & W2);
	endtask

	// Mid-run reset: outputs clear, cells keep their content
	task automatic t_reset();
		resetn = 1'h0;
		cycles(2);
		chk_word(freq_word, PTM_NV_RST);
		chk_bit(power_down, 1'h0);
		chk_bit(dout, 1'h0);
		resetn = 1'h1;
		cycles(6);
		chk_bit(shadow_in_control, 1'h0);
		i_ptm_prog_model.reload();
		chk_word(freq_word, W1 & W2);
	endtask

	initial begin
		mclk   = 1'h0;
		resetn = 1'h0;
		src    = 3'h0;
		repeat (12) @(posedge mclk);
		#1;
		resetn = 1'h1;
		cycles(6);
		t_mode_gate();
		t_routing();
		t_nv();
		t_reset();
		complete_run();
	end
endmodule // ptm_core_tb

// ### testbench/ptm_prog_model.sv
/*
 Programmer model: drives serial port, strobes, select lines, gate and
 programming pulses; reads the serial output back.
 Assumes mclk from the bench; pins change 1 ns after a rising edge.
*/
module ptm_prog_model
	import ptm_pkg::*;
#(
	parameter int PULSE_CYC = 16,
	parameter int GAP_CYC   = 24
)(
	input  wire logic mclk,
	input  wire logic dout,
	output logic      sclk,
	output logic      sdata,
	output logic      mode_strobe,
	output logic      sec_strobe,
	output logic      nv_select,
	output logic      nv_load,
	output logic      mode_gate_n,
	output logic      vpp_erase,
	output logic      vpp_write
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk        = 1'h0;
		sdata       = 1'h0;
		mode_strobe = 1'h0;
		sec_strobe  = 1'h0;
		nv_select   = 1'h0;
		nv_load     = 1'h0;
		mode_gate_n = 1'h1;
		vpp_erase   = 1'h0;
		vpp_write   = 1'h0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic ctl(input logic ss, input logic ns, input logic nl);
		sec_strobe = ss;
		nv_select  = ns;
		nv_load    = nl;
	endtask

	////////////////////////////////////////////////////////////////////
	// Serial frame, LSB first; dout sampled before each rise
	task automatic frame(input int n, input ptm_word_t bits,
		output ptm_word_t got);
		got = PTM_NV_RST;
		for (int i = 0; i < n; i++) begin
			got[i] = dout;
			sdata  = bits[i];
			step(4);
			sclk = 1'h1;
			step(4);
			sclk = 1'h0;
			step(4);
		end
		if (n < PTM_NV_W) begin
			got[n] = dout;
		end
		step(4);
		sdata = ~sdata;
	endtask

	task automatic shift_mode(input ptm_mode_t m);
		ptm_word_t got;
		ctl(1'h0, nv_select, 1'h0);
		mode_strobe = 1'h1;
		step(4);
		frame(10, {10'h000, m, 2'h3}, got);
	endtask

	task automatic strobe_mode();
		mode_strobe = 1'h0;
		step(6);
	endtask

	task automatic set_gate(input logic g);
		mode_gate_n = g;
		step(6);
	endtask

	////////////////////////////////////////////////////////////////////
	// Non-volatile operations
	task automatic pulse(input logic neg);
		vpp_erase = neg;
		vpp_write = ~neg;
		step(PULSE_CYC);
		vpp_erase = 1'h0;
		vpp_write = 1'h0;
		step(4);
	endtask

	task automatic erase();
		ctl(1'h1, 1'h1, 1'h1);
		step(4);
		pulse(1'h1);
		step(GAP_CYC);
	endtask

	task automatic write_word(input ptm_word_t w);
		ptm_word_t got;
		ctl(1'h0, 1'h0, 1'h1);
		step(4);
		frame(PTM_NV_W, w, got);
		ctl(1'h1, 1'h0, 1'h1);
		step(4);
		pulse(1'h0);
		ctl(1'h1, 1'h0, 1'h0);
		step(4);
	endtask

	task automatic reload();
		ctl(1'h0, 1'h1, 1'h1);
		step(4);
		ctl(1'h0, 1'h1, 1'h0);
		step(8);
	endtask

	task automatic shift_out(input int n, input ptm_word_t fill,
		output ptm_word_t got);
		ctl(sec_strobe, nv_select, 1'h1);
		step(6);
		frame(n, fill, got);
	endtask
endmodule // ptm_prog_model
